// File: cbi_top.sv
// cbi_top: bus interface logic of a universal counter with a
// microcode sequencer, measurement control and an Avalon-MM slave.
// assumes pins are asynchronous and software emulates the bus
// controller through the command register.
//
// Behaviour
// - wait-disable option suppresses service requests
// - max-cycle recycles; rate-pot sets the spacing
// - armed mode: channel B must arm measurement
// - storage holds result during running measurement
// - decade reset disable accumulates across measurements
// - overflow gives zero as leading readout character
// - talk-always acts as addressed to talk
// - respond only to switch-selected bus address
// - state counter drives rom address directly
// - process state: counter increments by one
// - octal state six drives inhibit low
// - decision state: jump when qualifier high
// - inverted decision: jump when qualifier low
// - free-running counter wraps 255 to zero
// - reset command: stop, time base zero, clear request
// - trigger only while addressed to listen
`timescale 1ns/10ps
`default_nettype none
module cbi_top
  import cbi_pkg::*;
#(
  parameter int CNT_W = 24
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // pins
  input  wire logic [4:0]  addr_switch,
  input  wire logic        chan_b_in,
  input  wire logic        count_in,
  input  wire logic [7:0]  sample_rate_control,
  // bus-side status
  output logic             srq,
  output logic             talk_active,
  output logic             listen_active,
  output logic             irq
);
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ARM  = 2'b01,
    M_GATE = 2'b10,
    M_DONE = 2'b11
  } cbi_meas_t;

  logic [14:0]       pins_s;
  logic [4:0]        sw_s;
  logic              chb_s;
  logic              cnt_s;
  logic [7:0]        pot_s;
  logic              chb_d;
  logic              cnt_d;
  logic              chb_edge;
  logic              cnt_edge;
  logic [CTRL_W-1:0] ctrl;
  logic [3:0]        cmd_code;
  logic [4:0]        cmd_addr;
  logic              cmd_pend;
  logic [7:0]        seq_state;
  logic              exec_cmd;
  logic              inhibit_n;
  logic              listen;
  logic              talk;
  logic              srq_pend;
  logic              trig_pend;
  cbi_meas_t         mstate;
  cbi_meas_t         next_mstate;
  logic [15:0]       gate_cnt;
  logic [15:0]       gate_len;
  logic [15:0]       rate_cnt;
  logic              recyc;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  held;
  logic              ovf;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_evt;
  logic              rd_done;
  logic [31:0]       rd_mux;

  // pin synchronisers
  cbi_sync #(.W(15)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({sample_rate_control, count_in, chan_b_in, addr_switch}),
    .dout  (pins_s)
  );
  assign sw_s  = pins_s[4:0];
  assign chb_s = pins_s[5];
  assign cnt_s = pins_s[6];
  assign pot_s = pins_s[14:7];

  // microcode sequencer paces command execution
  cbi_seq u_seq (
    .clk       (clk),
    .rst_n     (rst_n),
    .cmd_pend  (cmd_pend),
    .state     (seq_state),
    .exec_cmd  (exec_cmd),
    .inhibit_n (inhibit_n),
    .jump_en   ()
  );

  // bus decode; a command write stalls until the last one ran
  wire wr_ok    = avs_write & ~avs_waitrequest;
  wire sel_ctrl = (avs_address == REG_CTRL);
  wire sel_cmd  = (avs_address == REG_CMD);
  wire sel_res  = (avs_address == REG_RESULT);
  wire sel_ist  = (avs_address == REG_IRQ_STAT);
  wire sel_imk  = (avs_address == REG_IRQ_MASK);
  wire rd_ok    = avs_read & rd_done;
  assign avs_waitrequest = (avs_read & ~rd_done) |
                           (avs_write & sel_cmd & cmd_pend);

  // command decode, evaluated while the sequencer executes
  wire addr_hit = (cmd_addr == sw_s);
  wire do_exec  = exec_cmd & cmd_pend;
  wire do_reset = do_exec & ((cmd_code == CMD_RESET) |
                             (cmd_code == CMD_DEV_CLR));
  wire do_trig  = do_exec & (cmd_code == CMD_TRIGGER) &
                  listen;

  // control fields
  wire          f_run  = ctrl[CTRL_FUNC_RUN];
  wire [TB_W-1:0] f_tb = ctrl[CTRL_TB_LSB +: TB_W];
  wire          f_wdis = ctrl[CTRL_WAIT_DIS];
  wire          f_max  = ctrl[CTRL_MAX_CYC];
  wire          f_pot  = ctrl[CTRL_RATE_POT];
  wire          f_arm  = ctrl[CTRL_ARMED];
  wire          f_st   = ctrl[CTRL_STORE];
  wire          f_ddis = ctrl[CTRL_DEC_DIS];
  wire          f_talw = ctrl[CTRL_TALK_ALW];

  // control register; reset command forces stop and time base 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
    end else if (do_reset) begin
      ctrl[CTRL_FUNC_RUN]            <= 1'b0;
      ctrl[CTRL_TB_LSB +: TB_W]      <= '0;
    end else if (wr_ok & sel_ctrl) begin
      ctrl <= avs_writedata[CTRL_W-1:0];
    end
  end

  // command holding register, drained by the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_pend <= 1'b0;
      cmd_code <= 4'h0;
      cmd_addr <= 5'h00;
    end else if (wr_ok & sel_cmd) begin
      cmd_pend <= 1'b1;
      cmd_code <= avs_writedata[CMD_CODE_LSB +: CMD_CODE_W];
      cmd_addr <= avs_writedata[CMD_ADDR_LSB +: BUS_ADDR_W];
    end else if (do_exec) begin
      cmd_pend <= 1'b0;
    end
  end

  // addressing state; another device's address does not unlisten
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      listen <= 1'b0;
      talk   <= 1'b0;
    end else if (do_exec) begin
      case (cmd_code)
        CMD_LISTEN:   listen <= listen | addr_hit;
        CMD_UNLISTEN: listen <= 1'b0;
        CMD_TALK:     talk   <= addr_hit;
        CMD_UNTALK:   talk   <= 1'b0;
        default:      talk   <= talk;
      endcase
    end
  end
  assign listen_active = listen;
  assign talk_active   = talk | f_talw;

  // pin edges, taken from synchronised levels only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chb_d <= 1'b0;
      cnt_d <= 1'b0;
    end else begin
      chb_d <= chb_s;
      cnt_d <= cnt_s;
    end
  end
  assign chb_edge = chb_s & ~chb_d;
  assign cnt_edge = cnt_s & ~cnt_d;

  // gate length grows with the time base code
  assign gate_len = 16'(GATE_UNIT_CYC * (int'(f_tb) + 1));

  // measurement state machine; the sequencer can inhibit starts
  always_comb begin
    next_mstate = mstate;
    case (mstate)
      M_IDLE: begin
        if (trig_pend & f_run & inhibit_n) begin
          next_mstate = f_arm ? M_ARM : M_GATE;
        end
      end
      M_ARM: begin
        if (!f_run) begin
          next_mstate = M_IDLE;
        end else if (chb_edge) begin
          next_mstate = M_GATE;
        end
      end
      M_GATE: begin
        if (!f_run) begin
          next_mstate = M_IDLE;
        end else if (gate_cnt == 16'h0001) begin
          next_mstate = M_DONE;
        end
      end
      M_DONE:  next_mstate = M_IDLE;
      default: next_mstate = M_IDLE;
    endcase
  end

  wire gate_start = (next_mstate == M_GATE) & (mstate != M_GATE);
  wire meas_done  = (mstate == M_DONE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mstate   <= M_IDLE;
      gate_cnt <= 16'h0000;
    end else begin
      mstate   <= next_mstate;
      gate_cnt <= gate_start ? gate_len : gate_cnt - 16'h0001;
    end
  end

  // counting; decade reset disable keeps the previous total
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      ovf   <= 1'b0;
    end else if (do_reset) begin
      count <= '0;
      ovf   <= 1'b0;
    end else if (gate_start & ~f_ddis) begin
      count <= '0;
      ovf   <= 1'b0;
    end else if ((mstate == M_GATE) & cnt_edge) begin
      count <= count + 1'b1;
      if (&count) begin
        ovf <= 1'b1;
      end
    end
  end

  // storage holds the last finished result while counting runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
    end else if (do_reset) begin
      held <= '0;
    end else if (meas_done | ~f_st) begin
      held <= count;
    end
  end

  // trigger and recycle; pot spacing costs RATE_UNIT_CYC a step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_pend <= 1'b0;
      recyc     <= 1'b0;
      rate_cnt  <= 16'h0000;
    end else if (do_reset) begin
      trig_pend <= 1'b0;
      recyc     <= 1'b0;
    end else if (meas_done & f_max) begin
      recyc    <= 1'b1;
      rate_cnt <= f_pot ? 16'(pot_s * RATE_UNIT_CYC) : 16'h0000;
    end else if (recyc) begin
      if (rate_cnt == 16'h0000) begin
        recyc     <= 1'b0;
        trig_pend <= f_max;
      end else begin
        rate_cnt <= rate_cnt - 16'h0001;
      end
    end else if (do_trig) begin
      trig_pend <= 1'b1;
    end else if (mstate != M_IDLE) begin
      trig_pend <= 1'b0;
    end
  end

  // service request: set on completion, set beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srq_pend <= 1'b0;
    end else if (meas_done) begin
      srq_pend <= 1'b1;
    end else if (do_reset | (rd_ok & sel_res)) begin
      srq_pend <= 1'b0;
    end
  end
  assign srq = srq_pend & ~f_wdis;

  // interrupt status is write-one-to-clear; new events win
  assign irq_evt = {do_exec, meas_done & ovf, meas_done};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= irq_evt |
        (irq_stat & ~((wr_ok & sel_ist) ?
                      avs_writedata[IRQ_W-1:0] : '0));
      if (wr_ok & sel_imk) begin
        irq_mask <= avs_writedata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      REG_CTRL:     rd_mux[CTRL_W-1:0] = ctrl;
      REG_CMD:      rd_mux = {19'h0, cmd_addr, 3'h0, cmd_pend, cmd_code};
      REG_STATUS:   rd_mux = {17'h0, mstate, ovf, talk_active, listen,
                              srq_pend, cmd_pend, seq_state};
      REG_RESULT:   rd_mux[CNT_W-1:0] = f_st ? held : count;
      REG_READOUT:  rd_mux[7:0] = ovf ? LEAD_OVF : LEAD_NORM;
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // reads take one wait cycle so read data comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_done      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_done <= avs_read & ~rd_done;
      if (avs_read & ~rd_done) begin
        avs_readdata <= rd_mux;
      end
    end
  end
endmodule
`default_nettype wire

// File: cbi_pkg.sv
// cbi_pkg: constants and types for the counter bus interface block.
// assumes a single 200 MHz clock and an Avalon-MM register slave.
package cbi_pkg;

  // register byte offsets
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_CMD      = 5'h04;
  localparam logic [4:0] REG_STATUS   = 5'h08;
  localparam logic [4:0] REG_RESULT   = 5'h0C;
  localparam logic [4:0] REG_READOUT  = 5'h10;
  localparam logic [4:0] REG_IRQ_STAT = 5'h14;
  localparam logic [4:0] REG_IRQ_MASK = 5'h18;

  // control register fields
  localparam int CTRL_W        = 11;
  localparam int CTRL_FUNC_RUN = 0;
  localparam int CTRL_TB_LSB   = 1;
  localparam int TB_W          = 3;
  localparam int CTRL_WAIT_DIS = 4;
  localparam int CTRL_MAX_CYC  = 5;
  localparam int CTRL_RATE_POT = 6;
  localparam int CTRL_ARMED    = 7;
  localparam int CTRL_STORE    = 8;
  localparam int CTRL_DEC_DIS  = 9;
  localparam int CTRL_TALK_ALW = 10;
  localparam logic [10:0] CTRL_RST = 11'h100;

  // command register fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_CODE_W   = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int BUS_ADDR_W   = 5;

  typedef enum logic [3:0] {
    CMD_RESET    = 4'h0,
    CMD_LISTEN   = 4'h1,
    CMD_UNLISTEN = 4'h2,
    CMD_TALK     = 4'h3,
    CMD_UNTALK   = 4'h4,
    CMD_TRIGGER  = 4'h5,
    CMD_DEV_CLR  = 4'h6
  } cbi_cmd_t;

  // interrupt bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF  = 1;
  localparam int IRQ_CMD  = 2;

  // readout leading characters
  localparam logic [7:0] LEAD_OVF  = 8'h30;
  localparam logic [7:0] LEAD_NORM = 8'h2B;

  // timing
  localparam int CLK_NS       = 5;
  localparam int GATE_UNIT_NS = 1000;
  localparam int GATE_UNIT_CYC = (GATE_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RATE_UNIT_NS = 1000;
  localparam int RATE_UNIT_CYC = (RATE_UNIT_NS + CLK_NS - 1) / CLK_NS;

  // sequencer
  localparam logic [7:0] INHIBIT_STATE = 8'h06;

  typedef enum logic [1:0] {
    QUAL_ZERO = 2'b00,
    QUAL_CMD  = 2'b01,
    QUAL_ONE  = 2'b10
  } cbi_qual_t;

  typedef struct packed {
    logic       step_sel;
    logic       pol_hi;
    logic       pol_lo_n;
    cbi_qual_t  qual;
    logic       exec;
    logic [7:0] jump;
  } cbi_rom_t;

endpackage

// File: cbi_sync.sv
// cbi_sync: two-flop synchroniser for a bundle of pin inputs.
// assumes inputs are asynchronous levels; each bit is handled alone.
`timescale 1ns/10ps
`default_nettype none
module cbi_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        meta[i] <= din[i];
        dout[i] <= meta[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: cbi_seq.sv
// cbi_seq: rom-driven microcode sequencer with an 8-bit state counter.
// assumes the qualifier inputs come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cbi_seq
  import cbi_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // qualifier sources
  input  wire logic       cmd_pend,
  // sequencer outputs
  output logic      [7:0] state,
  output logic            exec_cmd,
  output logic            inhibit_n,
  output logic            jump_en
);
  cbi_rom_t rom_q;
  logic     qual;

  // microcode: idle loop polls for a command, then executes it
  function automatic cbi_rom_t rom_word(input logic [7:0] a);
    cbi_rom_t w;
    w = '{1'b0, 1'b0, 1'b1, QUAL_ZERO, 1'b0, 8'h00};
    case (a)
      8'h00: w = '{1'b1, 1'b1, 1'b1, QUAL_CMD, 1'b0, 8'h04};
      8'h01: w = '{1'b1, 1'b0, 1'b0, QUAL_CMD, 1'b0, 8'h00};
      8'h04: w = '{1'b0, 1'b0, 1'b1, QUAL_ZERO, 1'b1, 8'h00};
      8'h07: w = '{1'b1, 1'b1, 1'b1, QUAL_ONE, 1'b0, 8'h00};
      default: w = '{1'b0, 1'b0, 1'b1, QUAL_ZERO, 1'b0, 8'h00};
    endcase
    return w;
  endfunction

  // rom is addressed straight from the state counter, lsb to lsb
  assign rom_q = rom_word(state);
  assign qual  = (rom_q.qual == QUAL_CMD) ? cmd_pend :
                 (rom_q.qual == QUAL_ONE);
  // jump term: format bit and either polarity with the qualifier
  assign jump_en = rom_q.step_sel &
                   ((rom_q.pol_hi & qual) |
                    (~rom_q.pol_lo_n & ~qual));
  assign exec_cmd  = rom_q.exec;
  assign inhibit_n = (state != INHIBIT_STATE);

  // process states only increment; 255 wraps to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= 8'h00;
    end else if (jump_en) begin
      state <= rom_q.jump;
    end else begin
      state <= state + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: cbi_chk.sv
// cbi_chk: port-level assertions for cbi_top.
// assumes one clock domain; bound to cbi_top from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module cbi_chk
  import cbi_pkg::*;
#(
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // avalon-mm slave
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic [4:0]  addr_switch,
  input wire logic        chan_b_in,
  input wire logic        count_in,
  input wire logic [7:0]  sample_rate_control,
  // bus-side status
  input wire logic        srq,
  input wire logic        talk_active,
  input wire logic        listen_active,
  input wire logic        irq
);
  logic        wdis;
  logic        talw;
  logic [2:0]  mask;
  logic [12:0] lcode;
  wire        wr_ok  = avs_write && !avs_waitrequest;
  wire        cmd_wr = wr_ok && avs_address == REG_CMD;
  wire        ctl_wr = wr_ok && avs_address == REG_CTRL;

  // shadow bits, caught at the same edge that the slave takes a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdis  <= 1'b0;
      talw  <= 1'b0;
      mask  <= 3'h0;
      lcode <= '0;
    end else begin
      wdis  <= ctl_wr ? avs_writedata[CTRL_WAIT_DIS] : wdis;
      talw  <= ctl_wr ? avs_writedata[CTRL_TALK_ALW] : talw;
      mask  <= (wr_ok && avs_address == REG_IRQ_MASK) ?
               avs_writedata[2:0] : mask;
      lcode <= cmd_wr ? avs_writedata[12:0] : lcode;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_start;
    $rose(avs_read);
  endsequence
  sequence s_cmd(logic [3:0] c);
    cmd_wr && avs_writedata[3:0] == c;
  endsequence

  property p_rd_lat;
    s_rd_start |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  property p_wr_fast;
    avs_write && avs_address != REG_CMD |-> !avs_waitrequest;
  endproperty
  property p_cmd_wait;
    avs_write && avs_waitrequest |-> ##[1:16] !avs_waitrequest;
  endproperty
  property p_srq_dis;
    wdis |-> !srq;
  endproperty
  property p_talk_alw;
    talw |-> talk_active;
  endproperty
  // listen only ever rises on a listen to the switch address
  property p_listen_sel;
    $rose(listen_active) |-> lcode[3:0] == CMD_LISTEN &&
      lcode[12:8] == addr_switch;
  endproperty
  property p_talk_off;
    s_cmd(CMD_TALK) ##0 (avs_writedata[12:8] != addr_switch && !talw)
      |-> ##[1:24] !talk_active;
  endproperty
  property p_rst_cmd;
    s_cmd(CMD_RESET) |-> ##[1:24] !srq;
  endproperty
  property p_irq_mask;
    mask == 3'h0 |-> !irq;
  endproperty

  a_rd_lat: assert property (p_rd_lat)
    else $error("read did not answer after one wait");
  a_wr_fast: assert property (p_wr_fast)
    else $error("write stalled outside command register");
  a_cmd_wait: assert property (p_cmd_wait)
    else $error("command write stalled too long");
  a_srq_dis: assert property (p_srq_dis)
    else $error("service request while wait-disable set");
  a_talk_alw: assert property (p_talk_alw)
    else $error("talk-always set but not talking");
  a_listen_sel: assert property (p_listen_sel)
    else $error("listen rose without a listen command");
  a_talk_off: assert property (p_talk_off)
    else $error("talk kept after talk to another address");
  a_rst_cmd: assert property (p_rst_cmd)
    else $error("reset command left service request");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt with all sources masked");
endmodule
`default_nettype wire

// File: cbi_src.sv
// cbi_src: signal side of the counter, a square wave and a channel b pulse.
// assumes the bench drives half and arm right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module cbi_src (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control from the bench
  input  wire logic [7:0] half,
  input  wire logic       arm,
  // counter-side pins
  output logic            count_out,
  output logic            chan_b_out
);
  logic [7:0] cnt;
  logic [2:0] bcnt;

  // toggle every half cycles; zero parks the line low between tests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n || half == 8'h00) begin
      cnt       <= 8'h00;
      count_out <= 1'b0;
    end else if (cnt + 8'h01 >= half) begin
      cnt       <= 8'h00;
      count_out <= ~count_out;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // stretch the arm pulse so the two sync flops cannot miss it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt <= 3'h0;
    end else begin
      bcnt <= arm ? 3'h4 : (bcnt != 3'h0 ? bcnt - 3'h1 : bcnt);
    end
  end
  assign chan_b_out = bcnt != 3'h0;
endmodule
`default_nettype wire

// File: cbi_tb.sv
// cbi_tb: self-checking bench for cbi_top, software acting as controller.
// assumes cbi_pkg, cbi_src and cbi_chk are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cbi_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, arm = 1'b0;
  logic [4:0]  avs_address = 5'h00, addr_switch = 5'h00, sw, oth;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rv, r1;
  logic        avs_waitrequest, count_in, chan_b_in;
  logic [7:0]  sample_rate_control = 8'h00, half = 8'h00;
  logic        srq, talk_active, listen_active, irq;
  int          n_mismatch = 0, cmp_count = 0, cyc;
  cbi_cmd_t    clr_codes [2] = '{CMD_RESET, CMD_DEV_CLR};

  // small counter width so overflow is reachable in a short run
  cbi_top #(.CNT_W(8)) dut (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .addr_switch(addr_switch),
    .chan_b_in(chan_b_in), .count_in(count_in),
    .sample_rate_control(sample_rate_control), .srq(srq),
    .talk_active(talk_active), .listen_active(listen_active), .irq(irq));
  cbi_src src (.clk(clk), .rst_n(rst_n), .half(half), .arm(arm),
    .count_out(count_in), .chan_b_out(chan_b_in));

  always #2.5 clk = ~clk;

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // one bus cycle; held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, r1);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  // command write, then poll until the sequencer has taken it
  task automatic cmd(input cbi_cmd_t c, input logic [4:0] a);
    wr(REG_CMD, {19'h0, a, 4'h0, c});
    do rd(REG_STATUS, rv); while (rv[8] === 1'b1);
    rd(REG_STATUS, rv);
  endtask
  task automatic wait_done(input int lim);
    for (cyc = 0; irq !== 1'b1 && cyc < lim; cyc++) @(posedge clk);
  endtask
  // model count: rising edges of the square wave inside the gate
  task automatic cnt_chk(input logic [31:0] got, input int tb, h, k);
    int e;
    e = k * GATE_UNIT_CYC * (tb + 1) / (2 * h);
    chk(32'(got + 2 >= e && got <= e + 2), 32'h1, "count");
  endtask
  task automatic measure(input int lim);
    cmd(CMD_TRIGGER, 5'h00);
    wait_done(lim);
  endtask

  initial begin
    void'($urandom(32'h9523A0DF));
    sw  = 5'($urandom);
    oth = sw ^ 5'($urandom_range(30, 0) + 1);
    addr_switch <= sw;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL, rv);     chk(rv, 32'(CTRL_RST), "ctrl reset");
    rd(REG_STATUS, rv);   chk(32'(rv[7:0] <= 8'h01), 1, "state");
    wr(5'h1C, 32'hFFFFFFFF);
    rd(5'h1C, rv);        chk(rv, 32'h0, "unmapped");
    wr(REG_IRQ_MASK, 32'h1);
    rd(REG_IRQ_MASK, rv); chk(rv, 32'h1, "mask");
    // decode: only the switch address addresses the port
    cmd(CMD_LISTEN, oth); chk(32'(listen_active), 0, "listen");
    cmd(CMD_TALK, sw);    chk(32'(talk_active), 1, "talk");
    cmd(CMD_TALK, oth);   chk(32'(talk_active), 0, "talk");
    cmd(CMD_TALK, sw);
    wr(REG_CMD, {28'h0, CMD_UNTALK});
    cmd(CMD_UNLISTEN, 5'h00); chk(32'(talk_active), 0, "untalk");
    // trigger ignored while unaddressed, taken once listening
    half <= 8'h05;
    wr(REG_CTRL, 32'h101);
    measure(800);         chk(32'(irq), 0, "stray trigger");
    cmd(CMD_LISTEN, sw);  chk(32'(listen_active), 1, "listen");
    measure(800);         chk(32'(srq), 1, "srq");
    wr(REG_IRQ_MASK, 32'h0);
    chk(32'(irq), 0, "masked");
    wr(REG_IRQ_MASK, 32'h1);
    rd(REG_READOUT, rv);  chk(32'(rv[7:0]), 32'(LEAD_NORM), "lead");
    rd(REG_RESULT, rv);   cnt_chk(rv, 0, 5, 1);
    chk(32'(srq), 0, "srq read");
    wr(REG_IRQ_STAT, 32'h7);
    chk(32'(irq), 0, "w1c");
    // reset and device clear: stop, time base zero, request gone
    foreach (clr_codes[i]) begin
      wr(REG_CTRL, 32'h10B);
      measure(2000);
      cmd(clr_codes[i], 5'h00);
      rd(REG_CTRL, rv);   chk(rv & 32'hF, 32'h0, "clear");
      chk(32'(srq), 0, "clear srq");
      wr(REG_IRQ_STAT, 32'h7);
      cmd(CMD_LISTEN, sw);
    end
    wr(REG_CTRL, 32'h111);
    measure(800);         chk(32'(srq), 0, "wait-disable");
    wr(REG_IRQ_STAT, 32'h7);
    // armed: nothing until channel b fires
    wr(REG_CTRL, 32'h181);
    measure(800);         chk(32'(irq), 0, "unarmed");
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    wait_done(800);       chk(32'(irq), 1, "armed");
    wr(REG_IRQ_STAT, 32'h7);
    // decade reset disable accumulates across measurements
    cmd(CMD_RESET, 5'h00);
    cmd(CMD_LISTEN, sw);
    wr(REG_CTRL, 32'h301);
    for (int k = 1; k <= 2; k++) begin
      measure(800);
      rd(REG_RESULT, rv); cnt_chk(rv, 0, 5, k);
      wr(REG_IRQ_STAT, 32'h7);
    end
    // storage on holds the last result, off follows the count
    wr(REG_CTRL, 32'h10F);
    cmd(CMD_TRIGGER, 5'h00);
    repeat (400) @(posedge clk);
    rd(REG_RESULT, r1);
    rd(REG_RESULT, rv);   chk(rv, r1, "held");
    chk(32'(r1 != 0), 1, "held nonzero");
    wr(REG_CTRL, 32'h00F);
    rd(REG_RESULT, r1);
    repeat (20) @(posedge clk);
    rd(REG_RESULT, rv);   chk(32'(rv != r1), 1, "running");
    wait_done(2000);
    wr(REG_IRQ_STAT, 32'h7);
    // max cycle recycles at once; with rate pot the spacing grows
    wr(REG_CTRL, 32'h121);
    measure(800);
    wr(REG_IRQ_STAT, 32'h7);
    wait_done(400);       chk(32'(irq), 1, "recycle");
    sample_rate_control <= 8'h04;
    wr(REG_CTRL, 32'h161);
    wr(REG_IRQ_STAT, 32'h7);
    wait_done(1500);
    wr(REG_IRQ_STAT, 32'h7);
    wait_done(500);       chk(32'(irq), 0, "pot spacing");
    wr(REG_CTRL, 32'h100);
    wait_done(1500);
    wr(REG_IRQ_STAT, 32'h7);
    wr(REG_CTRL, 32'h500);
    chk(32'(talk_active), 1, "talk always");
    // fast input over a long gate wraps the count
    half <= 8'h01;
    wr(REG_CTRL, 32'h107);
    measure(2000);
    rd(REG_READOUT, rv);  chk(32'(rv[7:0]), 32'(LEAD_OVF), "ovf");
    end_of_test();
  end

  // watchdog: the sequence above needs well under this many cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule

bind cbi_top cbi_chk #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .addr_switch(addr_switch),
  .chan_b_in(chan_b_in), .count_in(count_in),
  .sample_rate_control(sample_rate_control), .srq(srq),
  .talk_active(talk_active), .listen_active(listen_active), .irq(irq));
`default_nettype wire
